// ==== admc_pkg.sv ====
// constants, mode and state types for the analog die mode and interrupt control
// assumes a 100 MHz system clock and a separate link clock for the spi side
package admc_pkg;
    localparam int unsigned ClkHz = 100_000_000;
    localparam int unsigned FirstTrigMs = 150;
    localparam int unsigned DefPeriodMs = 150;
    localparam int unsigned FirstTrigCycles = FirstTrigMs * (ClkHz / 1000);
    localparam int unsigned DefPeriodCycles = DefPeriodMs * (ClkHz / 1000);
    localparam int unsigned ResetHoldCycles = 16;
    localparam int unsigned IrqPulseCycles = 8;
    localparam int unsigned CntW = 32;
    localparam logic [1:0] ModeNormal = 2'h0;
    localparam logic [1:0] ModeStop = 2'h1;
    localparam logic [1:0] ModeSleep = 2'h2;
    localparam logic [1:0] ModeTrigger = 2'h3;
    // source bit positions
    localparam int unsigned SrcLowV = 0;
    localparam int unsigned SrcHighV = 1;
    localparam int unsigned SrcRegTemp = 2;
    localparam int unsigned SrcSwTemp = 3;
    localparam int unsigned SrcWakeOne = 4;
    localparam int unsigned SrcWakeTwo = 5;
    localparam int unsigned SrcLinWake = 6;
    localparam int unsigned SrcW = 7;
    localparam logic [SrcW-1:0] SrcReset = 7'h00;
    typedef enum {StReset, StNormReq, StNormal, StStop, StSleep} admc_state_t;
endpackage

// ==== admc_mode_ctrl.sv ====
// mode sequencer, watchdog, switch gating and interrupt pulse generator
// assumes mode/trigger/strobes arrive from spi logic on linkClk; pins are async
`timescale 1ns/1ps
module admc_mode_ctrl
    import admc_pkg::*;
#(
    parameter int unsigned FIRST_TRIG_CYCLES = FirstTrigCycles,
    parameter int unsigned WD_PERIOD_CYCLES = DefPeriodCycles
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic linkRst_n,
    // link side: mode write strobe, status read strobe, select rising edge
    input wire logic [1:0] operating_mode_field,
    input wire logic modeWrite,
    input wire logic statusRead,
    input wire logic selRise,
    input wire logic hsOneBit,
    input wire logic hsTwoBit,
    input wire logic hsThreeBit,
    output logic [SrcW-1:0] interrupt_source_bit,
    output logic [1:0] wakeLevels,
    // pins
    input wire logic switch_pwm_gate_input,
    input wire logic watchdog_config_pin,
    input wire logic wdPinOpen,
    input wire logic wake_input_one,
    input wire logic wake_input_two,
    input wire logic linWake,
    input wire logic mainSupplyLow,
    input wire logic mainSupplyHigh,
    input wire logic regTempHigh,
    input wire logic switchTempHigh,
    output logic high_side_out_one,
    output logic high_side_out_two,
    output logic high_side_out_three,
    output logic low_voltage_flag,
    output logic high_voltage_flag,
    output logic regulator_temp_flag,
    output logic switch_thermal_flag,
    output logic hostReset_n,
    output logic irq_n,
    output logic regulatorOn,
    output logic regulatorLimited,
    output logic linTxEnable,
    output logic senseAmpOn
);
    admc_state_t state_q, state_d;

    // ---------------- pin synchronisers
    logic [9:0] pinMeta_q, pinSync_q;
    logic [9:0] pinRaw;
    assign pinRaw = {switch_pwm_gate_input, watchdog_config_pin, wdPinOpen, wake_input_one,
                     wake_input_two, linWake, mainSupplyLow, mainSupplyHigh, regTempHigh,
                     switchTempHigh};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= 10'h000;
            pinSync_q <= 10'h000;
        end else if (clkEn) begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end
    logic pwmS, wdPinS, wdOpenS, wakeOneS, wakeTwoS, linWakeS, lowS, highS, regTS, swTS;
    assign {pwmS, wdPinS, wdOpenS, wakeOneS, wakeTwoS, linWakeS, lowS, highS, regTS, swTS}
        = pinSync_q;

    // ---------------- link -> sys: mode word via toggle handshake
    logic [1:0] modeHold_q;
    logic modeTog_q, selTog_q;
    logic [2:0] hsHold_q;
    always_ff @(posedge linkClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            modeHold_q <= ModeNormal;
            modeTog_q <= 1'b0;
            selTog_q <= 1'b0;
            hsHold_q <= 3'h0;
        end else begin
            hsHold_q <= {hsThreeBit, hsTwoBit, hsOneBit};
            if (modeWrite) begin
                modeHold_q <= operating_mode_field;
                modeTog_q <= ~modeTog_q;
            end
            if (selRise)
                selTog_q <= ~selTog_q;
        end
    end
    logic [2:0] modeTogS_q, selTogS_q;
    logic [2:0] hsMeta_q, hsS_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modeTogS_q <= 3'h0;
            selTogS_q <= 3'h0;
            hsMeta_q <= 3'h0;
            hsS_q <= 3'h0;
        end else if (clkEn) begin
            modeTogS_q <= {modeTogS_q[1:0], modeTog_q};
            selTogS_q <= {selTogS_q[1:0], selTog_q};
            hsMeta_q <= hsHold_q;
            hsS_q <= hsMeta_q;
        end
    end
    logic modeCmd, selEvt;
    assign modeCmd = modeTogS_q[2] != modeTogS_q[1];
    assign selEvt = selTogS_q[2] != selTogS_q[1];
    // mode word is stable while the toggle edge is seen
    logic [1:0] cmdMode;
    assign cmdMode = modeHold_q;

    // ---------------- watchdog
    logic wdEnable;
    assign wdEnable = wdPinS | wdOpenS;
    logic [CntW-1:0] wdCnt_q;
    logic wdFail, trig;
    assign trig = modeCmd && cmdMode == ModeTrigger;
    always_comb begin
        wdFail = 1'b0;
        if (wdEnable) begin
            if (state_q == StNormReq && wdCnt_q >= CntW'(FIRST_TRIG_CYCLES) && !trig)
                wdFail = 1'b1;
            if (state_q == StNormal) begin
                if (trig && wdCnt_q < CntW'(WD_PERIOD_CYCLES / 2))
                    wdFail = 1'b1;
                if (!trig && wdCnt_q >= CntW'(WD_PERIOD_CYCLES))
                    wdFail = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            wdCnt_q <= '0;
        else if (clkEn) begin
            if (state_d != state_q || trig || !wdEnable)
                wdCnt_q <= '0;
            else if (state_q == StNormReq || state_q == StNormal)
                wdCnt_q <= wdCnt_q + 1'b1;
        end
    end

    // ---------------- wake detection
    logic wakeOneP_q, wakeTwoP_q, linWakeP_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wakeOneP_q <= 1'b0;
            wakeTwoP_q <= 1'b0;
            linWakeP_q <= 1'b0;
        end else if (clkEn) begin
            wakeOneP_q <= wakeOneS;
            wakeTwoP_q <= wakeTwoS;
            linWakeP_q <= linWakeS;
        end
    end
    logic wOne, wTwo, wLin, lowPower, wakeAny;
    assign lowPower = state_q == StStop || state_q == StSleep;
    assign wOne = lowPower && wakeOneS != wakeOneP_q;
    assign wTwo = lowPower && wakeTwoS != wakeTwoP_q;
    assign wLin = lowPower && linWakeS && !linWakeP_q;
    assign wakeAny = wOne || wTwo || wLin || (state_q == StStop && selEvt);

    // ---------------- mode state machine
    logic [4:0] rstCnt_q;
    always_comb begin
        state_d = state_q;
        case (state_q)
            StReset:
                if (rstCnt_q >= 5'(ResetHoldCycles))
                    state_d = StNormReq;
            StNormReq:
                if (wdFail)
                    state_d = StReset;
                else if (trig || !wdEnable)
                    state_d = StNormal;
            StNormal:
                if (wdFail)
                    state_d = StReset;
                else if (modeCmd && cmdMode == ModeStop)
                    state_d = StStop;
                else if (modeCmd && cmdMode == ModeSleep)
                    state_d = StSleep;
            StStop:
                if (wakeAny)
                    state_d = StNormal;
            StSleep:
                if (wakeAny)
                    state_d = StReset;
            default:
                state_d = StReset;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            state_q <= StReset;
        else if (clkEn)
            state_q <= state_d;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rstCnt_q <= 5'h00;
        else if (clkEn)
            rstCnt_q <= (state_q == StReset) ? rstCnt_q + 5'h01 : 5'h00;
    end

    // ---------------- fault flags and sources
    logic monOn;
    // follows the next state so flags drop on the edge that enters low power
    assign monOn = state_d == StNormal || state_d == StNormReq;
    logic lowEvt, highEvt, regEvt, swEvt;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_voltage_flag <= 1'b0;
            high_voltage_flag <= 1'b0;
            regulator_temp_flag <= 1'b0;
            switch_thermal_flag <= 1'b0;
        end else if (clkEn) begin
            low_voltage_flag <= monOn && lowS;
            high_voltage_flag <= monOn && highS;
            regulator_temp_flag <= monOn && regTS;
            switch_thermal_flag <= monOn && swTS;
        end
    end
    assign lowEvt = monOn && lowS && !low_voltage_flag;
    assign highEvt = monOn && highS && !high_voltage_flag;
    assign regEvt = monOn && regTS && !regulator_temp_flag;
    assign swEvt = monOn && swTS && !switch_thermal_flag;
    logic [SrcW-1:0] newSrc;
    always_comb begin
        newSrc = SrcReset;
        newSrc[SrcLowV] = lowEvt;
        newSrc[SrcHighV] = highEvt;
        newSrc[SrcRegTemp] = regEvt;
        newSrc[SrcSwTemp] = swEvt;
        newSrc[SrcWakeOne] = state_q == StStop && wOne;
        newSrc[SrcWakeTwo] = state_q == StStop && wTwo;
        newSrc[SrcLinWake] = state_q == StStop && wLin;
    end

    // ---------------- source bits: cleared by one status read, set wins
    logic [2:0] rdTogS_q;
    logic rdTog_q;
    always_ff @(posedge linkClk or negedge linkRst_n) begin
        if (!linkRst_n)
            rdTog_q <= 1'b0;
        else if (statusRead)
            rdTog_q <= ~rdTog_q;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rdTogS_q <= 3'h0;
        else if (clkEn)
            rdTogS_q <= {rdTogS_q[1:0], rdTog_q};
    end
    logic [SrcW-1:0] src_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            src_q <= SrcReset;
        else if (clkEn) begin
            if (rdTogS_q[2] != rdTogS_q[1])
                src_q <= newSrc;
            else
                src_q <= src_q | newSrc;
        end
    end
    // source word into the link domain by a toggle handshake, never torn
    logic [SrcW-1:0] srcHold_q;
    logic srcReq_q;
    logic [1:0] srcAckS_q;
    logic [2:0] srcReqS_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srcHold_q <= SrcReset;
            srcReq_q <= 1'b0;
            srcAckS_q <= 2'h0;
        end else if (clkEn) begin
            srcAckS_q <= {srcAckS_q[0], srcReqS_q[2]};
            if (srcAckS_q[1] == srcReq_q && srcHold_q != src_q) begin
                srcHold_q <= src_q;
                srcReq_q <= ~srcReq_q;
            end
        end
    end
    // registered mode bit, so the link side never sees a decoder glitch
    logic inNormal_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            inNormal_q <= 1'b0;
        else if (clkEn)
            inNormal_q <= state_q == StNormal;
    end
    logic [1:0] wakeMeta_q;
    logic normMeta_q, normS_q;
    always_ff @(posedge linkClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            srcReqS_q <= 3'h0;
            interrupt_source_bit <= SrcReset;
            wakeMeta_q <= 2'h0;
            normMeta_q <= 1'b0;
            normS_q <= 1'b0;
            wakeLevels <= 2'h0;
        end else begin
            srcReqS_q <= {srcReqS_q[1:0], srcReq_q};
            if (srcReqS_q[2] != srcReqS_q[1])
                interrupt_source_bit <= srcHold_q;
            wakeMeta_q <= {wakeTwoS, wakeOneS};
            normMeta_q <= inNormal_q;
            normS_q <= normMeta_q;
            wakeLevels <= normS_q ? wakeMeta_q : 2'h0;
        end
    end

    // ---------------- interrupt pulse
    logic [3:0] irqCnt_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqCnt_q <= 4'h0;
            irq_n <= 1'b1;
        end else if (clkEn) begin
            if (irqCnt_q != 4'h0) begin
                irqCnt_q <= irqCnt_q - 4'h1;
                irq_n <= irqCnt_q == 4'h1;
            end else if (|newSrc || (state_q == StStop && state_d == StNormal)) begin
                irqCnt_q <= 4'(IrqPulseCycles);
                irq_n <= 1'b0;
            end else
                irq_n <= 1'b1;
        end
    end

    // ---------------- outputs per mode
    logic swAllow;
    // next state, so switches drop on the same edge as reset and low power
    assign swAllow = (state_d == StNormReq || state_d == StNormal) && !swTS;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            high_side_out_one <= 1'b0;
            high_side_out_two <= 1'b0;
            high_side_out_three <= 1'b0;
            hostReset_n <= 1'b0;
            regulatorOn <= 1'b1;
            regulatorLimited <= 1'b0;
            linTxEnable <= 1'b0;
            senseAmpOn <= 1'b0;
        end else if (clkEn) begin
            high_side_out_one <= swAllow && hsS_q[0] && pwmS;
            high_side_out_two <= swAllow && hsS_q[1] && pwmS;
            high_side_out_three <= swAllow && hsS_q[2];
            hostReset_n <= state_d != StReset && state_d != StSleep;
            regulatorOn <= state_d != StSleep;
            regulatorLimited <= state_d == StStop;
            linTxEnable <= state_d == StNormReq || state_d == StNormal;
            senseAmpOn <= state_d == StNormal;
        end
    end
endmodule // admc_mode_ctrl

// ==== admc_mode_ctrl_checker.sv ====
// assertions on the mode and interrupt control ports
// assumes binding to admc_mode_ctrl, single clk_sys domain
`timescale 1ns/1ps
module admc_mode_ctrl_checker
    import admc_pkg::*;
#(
    parameter int unsigned FIRST_TRIG_CYCLES = FirstTrigCycles,
    parameter int unsigned WD_PERIOD_CYCLES = DefPeriodCycles
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic switch_pwm_gate_input,
    input wire logic mainSupplyLow,
    input wire logic switchTempHigh,
    input wire logic high_side_out_one,
    input wire logic high_side_out_two,
    input wire logic high_side_out_three,
    input wire logic low_voltage_flag,
    input wire logic high_voltage_flag,
    input wire logic hostReset_n,
    input wire logic irq_n,
    input wire logic regulatorOn,
    input wire logic regulatorLimited,
    input wire logic linTxEnable,
    input wire logic senseAmpOn
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic anySw;
    assign anySw = high_side_out_one | high_side_out_two | high_side_out_three;
    reset_state_off_a: assert property (!hostReset_n |-> !anySw && !linTxEnable)
        else $error("switches or lin on while host held in reset");
    stop_outputs_a: assert property (regulatorLimited |-> !anySw && !linTxEnable && hostReset_n)
        else $error("stop mode outputs wrong");
    sleep_reset_a: assert property (!regulatorOn |-> !hostReset_n && !anySw)
        else $error("regulator off without reset");
    pwm_gate_a: assert property (!switch_pwm_gate_input [*5] |-> !high_side_out_one && !high_side_out_two)
        else $error("switch one or two on with gate low");
    thermal_off_a: assert property (switchTempHigh [*5] |-> !anySw)
        else $error("switch on during overtemperature");
    irq_width_a: assert property ($fell(irq_n) |-> ##1 (!irq_n) [*7] ##1 irq_n)
        else $error("interrupt pulse width wrong");
    low_flag_set_a: assert property ((mainSupplyLow && linTxEnable) [*5] |-> low_voltage_flag)
        else $error("low voltage flag missing");
    monitor_off_a: assert property ((low_voltage_flag || high_voltage_flag) |-> !regulatorLimited && regulatorOn)
        else $error("supply flag set in low power mode");
    amp_normal_a: assert property (senseAmpOn |-> hostReset_n && linTxEnable && !regulatorLimited)
        else $error("sense amp on outside normal");
    cover property ($fell(irq_n));
    cover property ($rose(regulatorLimited));
    cover property ($fell(regulatorOn));
endmodule // admc_mode_ctrl_checker

bind admc_mode_ctrl admc_mode_ctrl_checker #(
    .FIRST_TRIG_CYCLES(FIRST_TRIG_CYCLES),
    .WD_PERIOD_CYCLES(WD_PERIOD_CYCLES)
) chk (.clk_sys, .rst_n, .switch_pwm_gate_input, .mainSupplyLow, .switchTempHigh,
    .high_side_out_one, .high_side_out_two, .high_side_out_three, .low_voltage_flag,
    .high_voltage_flag, .hostReset_n, .irq_n, .regulatorOn, .regulatorLimited, .linTxEnable,
    .senseAmpOn);

// ==== admc_host_model.sv ====
// host side of the link: mode writes, status transfers, select edges, switch bits
// assumes linkClk from the bench; changes just after each rising edge
`timescale 1ns/1ps
module admc_host_model
    import admc_pkg::*;
(
    input wire logic linkClk,
    output logic [1:0] operating_mode_field,
    output logic modeWrite,
    output logic statusRead,
    output logic selRise,
    output logic hsOneBit,
    output logic hsTwoBit,
    output logic hsThreeBit,
    input wire logic [SrcW-1:0] interrupt_source_bit
);
    initial begin
        operating_mode_field = 2'h0;
        modeWrite = 1'b0;
        statusRead = 1'b0;
        selRise = 1'b0;
        {hsThreeBit, hsTwoBit, hsOneBit} = 3'h0;
    end
    task automatic writeMode(input logic [1:0] m);
        @(posedge linkClk);
        #1;
        operating_mode_field = m;
        modeWrite = 1'b1;
        @(posedge linkClk);
        #1;
        modeWrite = 1'b0;
        operating_mode_field = ~m;
        repeat (4) @(posedge linkClk);
    endtask
    task automatic readStatus(output logic [SrcW-1:0] s);
        @(posedge linkClk);
        #1;
        s = interrupt_source_bit;
        statusRead = 1'b1;
        @(posedge linkClk);
        #1;
        statusRead = 1'b0;
        repeat (4) @(posedge linkClk);
    endtask
    task automatic selPulse();
        @(posedge linkClk);
        #1;
        selRise = 1'b1;
        @(posedge linkClk);
        #1;
        selRise = 1'b0;
    endtask
    task automatic setSw(input logic [2:0] b);
        @(posedge linkClk);
        #1;
        {hsThreeBit, hsTwoBit, hsOneBit} = b;
    endtask
endmodule // admc_host_model

// ==== test_analog_die_mode_and_interrupt_ctrl.sv ====
// self-checking bench for admc_mode_ctrl with host model on the link side
// assumes short watchdog counts of 200 and 100 cycles
`timescale 1ns/1ps
module test_analog_die_mode_and_interrupt_ctrl;
    import admc_pkg::*;
    logic clk_sys = 0, rst_n = 0, linkClk = 0, linkRst_n = 0, clkEn = 1;
    logic switch_pwm_gate_input = 1, watchdog_config_pin = 0, wdPinOpen = 0;
    logic wake_input_one = 0, wake_input_two = 0, linWake = 0;
    logic mainSupplyLow = 0, mainSupplyHigh = 0, regTempHigh = 0, switchTempHigh = 0;
    logic [1:0] operating_mode_field, wakeLevels;
    logic modeWrite, statusRead, selRise, hsOneBit, hsTwoBit, hsThreeBit;
    logic [SrcW-1:0] interrupt_source_bit, s;
    logic high_side_out_one, high_side_out_two, high_side_out_three, low_voltage_flag;
    logic high_voltage_flag, regulator_temp_flag, switch_thermal_flag, hostReset_n, irq_n;
    logic regulatorOn, regulatorLimited, linTxEnable, senseAmpOn;
    logic [3:0] f;
    logic [2:0] b;
    int mismatches = 0, compares = 0, e;
    int expQ[$];
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #32 linkClk = ~linkClk;
    end
    admc_host_model host (.linkClk, .operating_mode_field, .modeWrite, .statusRead, .selRise,
        .hsOneBit, .hsTwoBit, .hsThreeBit, .interrupt_source_bit);
    admc_mode_ctrl #(.FIRST_TRIG_CYCLES(200), .WD_PERIOD_CYCLES(100)) DUT (.clk_sys, .rst_n,
        .clkEn, .linkClk, .linkRst_n, .operating_mode_field, .modeWrite, .statusRead, .selRise,
        .hsOneBit, .hsTwoBit, .hsThreeBit, .interrupt_source_bit, .wakeLevels,
        .switch_pwm_gate_input, .watchdog_config_pin, .wdPinOpen, .wake_input_one,
        .wake_input_two, .linWake, .mainSupplyLow, .mainSupplyHigh, .regTempHigh,
        .switchTempHigh, .high_side_out_one, .high_side_out_two, .high_side_out_three,
        .low_voltage_flag, .high_voltage_flag, .regulator_temp_flag, .switch_thermal_flag,
        .hostReset_n, .irq_n, .regulatorOn, .regulatorLimited, .linTxEnable, .senseAmpOn);
    task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // 0 irq low, 1 reset released, 2 reset held, 3 amp on, 4 lin on
    task automatic waitSig(input int w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((w == 0 && irq_n === 1'b0) || (w == 1 && hostReset_n === 1'b1) ||
                (w == 2 && hostReset_n === 1'b0) || (w == 3 && senseAmpOn === 1'b1) ||
                (w == 4 && linTxEnable === 1'b1)) break;
            cyc(1);
        end
        if (i == lim) begin
            mismatches++;
            $display("[FAIL] wait %0d expected 1 seen 0", w);
            end_sim();
        end
    endtask
    initial begin
        void'($urandom(86209));
        cyc(10);
        check("resetOut", 7'h00, {hostReset_n, high_side_out_three, linTxEnable});
        rst_n = 1;
        linkRst_n = 1;
        waitSig(1, 60);
        cyc(2);
        check("wdOff", 7'h03, {linTxEnable, senseAmpOn});
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            b = $urandom;
            switch_pwm_gate_input = $urandom;
            host.setSw(b);
            cyc(20);
            expQ.push_back({b[2], b[1] & switch_pwm_gate_input, b[0] & switch_pwm_gate_input});
            check("switches", expQ.pop_front(),
                {high_side_out_three, high_side_out_two, high_side_out_one});
        end
        switch_pwm_gate_input = 1;
        host.setSw(3'h7);
        host.writeMode(ModeTrigger);
        waitSig(3, 60);
        $display("switch test done");
        for (int k = 0; k < 5; k++) begin
            e = (k == 4) ? 5 : (1 << k);
            {switchTempHigh, regTempHigh, mainSupplyHigh, mainSupplyLow} = e;
            waitSig(0, 40);
            cyc(25);
            f = {switch_thermal_flag, regulator_temp_flag, high_voltage_flag, low_voltage_flag};
            check("flags", e, f);
            if (k == 3) check("hotSw", 7'h00, high_side_out_one | high_side_out_three);
            host.readStatus(s);
            check("source", e, s);
            host.readStatus(s);
            check("sourceOnce", 7'h00, s);
            {switchTempHigh, regTempHigh, mainSupplyHigh, mainSupplyLow} = 4'h0;
            cyc(12);
            check("flagsGone", 7'h00, low_voltage_flag | regulator_temp_flag);
        end
        $display("fault test done");
        for (int k = 0; k < 3; k++) begin
            host.writeMode(ModeStop);
            mainSupplyLow = 1;
            cyc(20);
            check("stop", 7'h12, {regulatorLimited, linTxEnable, high_side_out_one, hostReset_n,
                low_voltage_flag});
            mainSupplyLow = 0;
            cyc(5);
            if (k == 0) wake_input_one = ~wake_input_one;
            if (k == 1) linWake = 1;
            if (k == 2) host.selPulse();
            waitSig(0, 80);
            waitSig(4, 40);
            linWake = 0;
            check("noReset", 7'h01, hostReset_n);
            cyc(25);
            host.readStatus(s);
            check("wakeSrc", (k == 0) ? 7'h10 : (k == 1) ? 7'h40 : 7'h00, s);
            check("wakeLevels", {wake_input_two, wake_input_one}, wakeLevels);
        end
        $display("stop test done");
        host.writeMode(ModeSleep);
        waitSig(2, 60);
        cyc(5);
        check("sleep", 7'h00, {regulatorOn, hostReset_n, linTxEnable, wakeLevels});
        wake_input_two = 1;
        cyc(10);
        check("sleepWake", 7'h02, {regulatorOn, hostReset_n});
        waitSig(1, 60);
        $display("sleep test done");
        wdPinOpen = 1;
        waitSig(2, 300);
        waitSig(1, 60);
        cyc(2);
        check("normReq", 7'h02, {linTxEnable, senseAmpOn});
        host.writeMode(ModeTrigger);
        waitSig(3, 60);
        cyc(35);
        host.writeMode(ModeTrigger);
        check("openWin", 7'h03, {hostReset_n, senseAmpOn});
        fork
            host.writeMode(ModeTrigger);
            waitSig(2, 60);
        join
        $display("watchdog test done");
        end_sim();
    end
endmodule // test_analog_die_mode_and_interrupt_ctrl
